// ---- rtl/mem_map_pkg.sv ----
// Constants for the data, program and stack space decoder
package mem_map_pkg;
	localparam int DATA_AW = 8;
	localparam int PROG_AW = 12;
	localparam int STACK_DEPTH = 6;
	localparam int WIN_SEL_W = 6;
	localparam int WIN_OFS_W = 6;
	localparam int RAM_WORDS = 64;
	localparam logic [7:0] ADDR_WIN_LO = 8'h40;
	localparam logic [7:0] ADDR_WIN_HI = 8'h7F;
	localparam logic [7:0] ADDR_RAM_LO = 8'h84;
	localparam logic [7:0] ADDR_RAM_HI = 8'hBF;
	localparam logic [7:0] ADDR_IDX_X = 8'h80;
	localparam logic [7:0] ADDR_IDX_Y = 8'h81;
	localparam logic [7:0] ADDR_SD_V = 8'h82;
	localparam logic [7:0] ADDR_SD_W = 8'h83;
	localparam logic [7:0] ADDR_PA_LATCH = 8'hC0;
	localparam logic [7:0] ADDR_PB_LATCH = 8'hC1;
	localparam logic [7:0] ADDR_PA_DIR = 8'hC4;
	localparam logic [7:0] ADDR_PB_DIR = 8'hC5;
	localparam logic [7:0] ADDR_INT_OPT = 8'hC8;
	localparam logic [7:0] ADDR_WIN_SEL = 8'hC9;
	localparam logic [7:0] ADDR_PA_OPT = 8'hCC;
	localparam logic [7:0] ADDR_PB_OPT = 8'hCD;
	localparam logic [7:0] ADDR_CONV_RES = 8'hD0;
	localparam logic [7:0] ADDR_CONV_CTL = 8'hD1;
	localparam logic [7:0] ADDR_TMR_PSC = 8'hD2;
	localparam logic [7:0] ADDR_TMR_CNT = 8'hD3;
	localparam logic [7:0] ADDR_TMR_STC = 8'hD4;
	localparam logic [7:0] ADDR_WDG = 8'hD8;
	localparam logic [7:0] ADDR_ACC = 8'hFF;
	localparam logic [7:0] RST_PORT = 8'h00;
	localparam logic [7:0] RST_CONV_CTL = 8'h40;
	localparam logic [7:0] RST_TMR_PSC = 8'h7F;
	localparam logic [7:0] RST_TMR_CNT = 8'hFF;
	localparam logic [7:0] RST_TMR_STC = 8'h00;
	localparam logic [7:0] RST_WDG = 8'hFE;
	localparam logic [7:0] RST_UNDEF = 8'h00;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	// Program memory byte value after a full erase
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	// Converter control: bit 6 read-only, others write-only
	localparam logic [7:0] CONV_CTL_RO_MASK = 8'h40;
	localparam logic [2:0] STACK_PTR_ZERO = 3'h0;
endpackage

// ---- rtl/mem_map_decoder.sv ----
// Data space register map, data ROM window, program fetch and return stack
`timescale 1ns/1ps
`default_nettype none
module mem_map_decoder
	import mem_map_pkg::*;
#(
	parameter int PORT_W = 8
)
(
	input wire logic clk_sys, // System clock
	input wire logic srst, // Synchronous reset, active high
	input wire logic [mem_map_pkg::DATA_AW-1:0] data_addr, // Data address
	input wire logic data_wr, // Data write strobe
	input wire logic data_rd, // Data read strobe
	input wire logic [7:0] data_wdata, // Data write value
	output logic [7:0] data_rdata, // Data read value, registered
	input wire logic [mem_map_pkg::PROG_AW-1:0] prog_counter, // Fetch address
	output logic [7:0] prog_rdata, // Fetched byte, registered
	input wire logic stack_push, // Push return address
	input wire logic stack_pop, // Pop return address
	input wire logic [mem_map_pkg::PROG_AW-1:0] stack_wdata, // Pushed address
	output logic [mem_map_pkg::PROG_AW-1:0] stack_top, // Top entry
	output logic stack_full, // Six entries held
	output logic stack_empty, // No entry held
	input wire logic protect_opt, // Readout protection option
	input wire logic full_erase, // Whole program memory erase pulse
	input wire logic prog_load_we, // Programming write
	input wire logic [mem_map_pkg::PROG_AW-1:0] prog_load_addr, // Prog addr
	input wire logic [7:0] prog_load_data, // Programming data
	input wire logic ext_rd, // External readout request
	input wire logic [mem_map_pkg::PROG_AW-1:0] ext_addr, // Readout address
	output logic [7:0] ext_rdata, // Readout data, zero when refused
	output logic ext_refused, // Readout refused pulse
	input wire logic [PORT_W-1:0] port_a_pin, // Port A pin levels
	input wire logic [PORT_W-1:0] port_b_pin, // Port B pin levels
	output logic [PORT_W-1:0] port_a_out, // Port A output values
	output logic [PORT_W-1:0] port_a_oe, // Port A drive enables
	output logic [PORT_W-1:0] port_a_pullup, // Port A pull-up enables
	output logic [PORT_W-1:0] port_b_out, // Port B output values
	output logic [PORT_W-1:0] port_b_oe, // Port B drive enables
	output logic [PORT_W-1:0] port_b_pullup, // Port B pull-up enables
	input wire logic [7:0] conv_result_in, // Converter result value
	input wire logic conv_status_in, // Converter read-only status bit
	output logic [7:0] conv_control, // Converter write-only control bits
	output logic [7:0] interrupt_options_q, // Interrupt option value
	output logic [7:0] timer_prescaler_q, // Prescaler value
	output logic [7:0] timer_downcounter_q, // Downcounter value
	output logic [7:0] timer_status_control_q, // Timer status control
	output logic [7:0] watchdog_counter_q // Watchdog value
);
	import mem_map_pkg::*;

	localparam int PROG_BYTES = 1 << PROG_AW;

	// Storage for program, data and stack spaces
	logic [7:0] prog_mem [PROG_BYTES];
	logic [7:0] ram [RAM_WORDS];
	logic [PROG_AW-1:0] stack_mem [STACK_DEPTH];
	logic [2:0] stack_ptr_reg;
	logic [PROG_AW-1:0] stack_top_reg;
	logic protect_reg;
	// Pin synchroniser stages
	logic [PORT_W-1:0] pa_sync1;
	logic [PORT_W-1:0] pa_sync2;
	logic [PORT_W-1:0] pb_sync1;
	logic [PORT_W-1:0] pb_sync2;
	// Core registers
	logic [7:0] index_reg_x;
	logic [7:0] index_reg_y;
	logic [7:0] short_direct_reg_v;
	logic [7:0] short_direct_reg_w;
	logic [7:0] accumulator;
	// Port registers
	logic [PORT_W-1:0] port_a_output_latch;
	logic [PORT_W-1:0] port_b_output_latch;
	logic [PORT_W-1:0] port_a_direction;
	logic [PORT_W-1:0] port_b_direction;
	logic [PORT_W-1:0] port_a_pin_options;
	logic [PORT_W-1:0] port_b_pin_options;
	// Option, window, converter, timer and watchdog registers
	logic [7:0] interrupt_options;
	logic [7:0] rom_window_select;
	logic [7:0] converter_control;
	logic [7:0] timer_prescaler;
	logic [7:0] timer_downcounter;
	logic [7:0] timer_status_control;
	logic [7:0] watchdog_counter;
	// Read path
	logic [7:0] rd_next;
	logic [7:0] pa_read;
	logic [7:0] pb_read;

	// Address range test used by several decoders
	function automatic logic in_range(input logic [7:0] a,
		input logic [7:0] lo, input logic [7:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// Port read-back mixes latch and live pins per bit
	function automatic logic [PORT_W-1:0] port_view(
		input logic [PORT_W-1:0] dir, input logic [PORT_W-1:0] latch,
		input logic [PORT_W-1:0] pins);
		port_view = (dir & latch) | (~dir & pins);
	endfunction

	// Two-stage pin synchronisers
	always_ff @(posedge clk_sys)
	begin
		pa_sync1 <= port_a_pin;
		pa_sync2 <= pa_sync1;
		pb_sync1 <= port_b_pin;
		pb_sync2 <= pb_sync1;
	end

	// Program memory: whole erase, programming writes, counter fetch
	always_ff @(posedge clk_sys)
	begin
		if (full_erase)
		begin
			for (int i = 0; i < PROG_BYTES; i++)
				prog_mem[i] <= ERASED_BYTE;
		end
		else if (prog_load_we)
			prog_mem[prog_load_addr] <= prog_load_data;
		prog_rdata <= prog_mem[prog_counter];
	end

	// Protection latch: reset leaves it, only a full erase clears it
	always_ff @(posedge clk_sys)
	begin
		if (protect_opt)
			protect_reg <= 1'b1;
		else if (full_erase)
			protect_reg <= 1'b0;
	end

	// External readout, refused while protected
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			ext_rdata <= RD_UNMAPPED;
			ext_refused <= 1'b0;
		end
		else
		begin
			ext_refused <= ext_rd && (protect_reg || protect_opt);
			if (ext_rd && !(protect_reg || protect_opt))
				ext_rdata <= prog_mem[ext_addr];
			else
				ext_rdata <= RD_UNMAPPED;
		end
	end

	// Return stack, its own space with its own pointer
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			stack_ptr_reg <= STACK_PTR_ZERO;
		else if (stack_push && !stack_full)
		begin
			stack_mem[stack_ptr_reg] <= stack_wdata;
			stack_ptr_reg <= stack_ptr_reg + 3'h1;
		end
		else if (stack_pop && !stack_empty)
			stack_ptr_reg <= stack_ptr_reg - 3'h1;
	end

	// Stack level flags
	assign stack_full = (stack_ptr_reg == 3'(STACK_DEPTH));
	assign stack_empty = (stack_ptr_reg == STACK_PTR_ZERO);

	// Registered top of stack, follows every accepted push and pop
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			stack_top_reg <= '0;
		else if (stack_push && !stack_full)
			stack_top_reg <= stack_wdata;
		else if (stack_pop && !stack_empty)
		begin
			if (stack_ptr_reg == 3'h1)
				stack_top_reg <= '0;
			else
				stack_top_reg <= stack_mem[stack_ptr_reg - 3'h2];
		end
	end
	assign stack_top = stack_top_reg;

	// User RAM writes
	always_ff @(posedge clk_sys)
	begin
		if (data_wr && in_range(data_addr, ADDR_RAM_LO, ADDR_RAM_HI))
			ram[6'(data_addr - ADDR_RAM_LO)] <= data_wdata;
	end

	// Core registers, reset loads RST_UNDEF (zero)
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			index_reg_x <= RST_UNDEF;
			index_reg_y <= RST_UNDEF;
			short_direct_reg_v <= RST_UNDEF;
			short_direct_reg_w <= RST_UNDEF;
			accumulator <= RST_UNDEF;
		end
		else if (data_wr)
		begin
			unique case (data_addr)
				ADDR_IDX_X: index_reg_x <= data_wdata;
				ADDR_IDX_Y: index_reg_y <= data_wdata;
				ADDR_SD_V: short_direct_reg_v <= data_wdata;
				ADDR_SD_W: short_direct_reg_w <= data_wdata;
				ADDR_ACC: accumulator <= data_wdata;
				default: ;
			endcase
		end
	end

	// Port latches, directions and options
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			port_a_output_latch <= PORT_W'(RST_PORT);
			port_b_output_latch <= PORT_W'(RST_PORT);
			port_a_direction <= PORT_W'(RST_PORT);
			port_b_direction <= PORT_W'(RST_PORT);
			port_a_pin_options <= PORT_W'(RST_PORT);
			port_b_pin_options <= PORT_W'(RST_PORT);
		end
		else if (data_wr)
		begin
			unique case (data_addr)
				ADDR_PA_LATCH: port_a_output_latch <= PORT_W'(data_wdata);
				ADDR_PB_LATCH: port_b_output_latch <= PORT_W'(data_wdata);
				ADDR_PA_DIR: port_a_direction <= PORT_W'(data_wdata);
				ADDR_PB_DIR: port_b_direction <= PORT_W'(data_wdata);
				ADDR_PA_OPT: port_a_pin_options <= PORT_W'(data_wdata);
				ADDR_PB_OPT: port_b_pin_options <= PORT_W'(data_wdata);
				default: ;
			endcase
		end
	end

	// Write-only option and window select registers
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			interrupt_options <= RST_UNDEF;
			rom_window_select <= RST_UNDEF;
		end
		else if (data_wr)
		begin
			if (data_addr == ADDR_INT_OPT)
				interrupt_options <= data_wdata;
			if (data_addr == ADDR_WIN_SEL)
				rom_window_select <= data_wdata;
		end
	end

	// Converter control, timer and watchdog registers
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			converter_control <= RST_CONV_CTL;
			timer_prescaler <= RST_TMR_PSC;
			timer_downcounter <= RST_TMR_CNT;
			timer_status_control <= RST_TMR_STC;
			watchdog_counter <= RST_WDG;
		end
		else if (data_wr)
		begin
			unique case (data_addr)
				ADDR_CONV_CTL:
					converter_control <= (data_wdata & ~CONV_CTL_RO_MASK)
						| (converter_control & CONV_CTL_RO_MASK);
				ADDR_TMR_PSC: timer_prescaler <= data_wdata;
				ADDR_TMR_CNT: timer_downcounter <= data_wdata;
				ADDR_TMR_STC: timer_status_control <= data_wdata;
				ADDR_WDG: watchdog_counter <= data_wdata;
				default: ;
			endcase
		end
	end

	// Port views for reads
	assign pa_read = 8'(port_view(port_a_direction, port_a_output_latch,
		pa_sync2));
	assign pb_read = 8'(port_view(port_b_direction, port_b_output_latch,
		pb_sync2));

	// Data space read decode
	always_comb
	begin
		rd_next = RD_UNMAPPED;
		if (in_range(data_addr, ADDR_WIN_LO, ADDR_WIN_HI))
			rd_next = prog_mem[{rom_window_select[WIN_SEL_W-1:0],
				data_addr[WIN_OFS_W-1:0]}];
		else if (in_range(data_addr, ADDR_RAM_LO, ADDR_RAM_HI))
			rd_next = ram[6'(data_addr - ADDR_RAM_LO)];
		else
		begin
			unique case (data_addr)
				ADDR_IDX_X: rd_next = index_reg_x;
				ADDR_IDX_Y: rd_next = index_reg_y;
				ADDR_SD_V: rd_next = short_direct_reg_v;
				ADDR_SD_W: rd_next = short_direct_reg_w;
				ADDR_ACC: rd_next = accumulator;
				ADDR_PA_LATCH: rd_next = pa_read;
				ADDR_PB_LATCH: rd_next = pb_read;
				ADDR_PA_DIR: rd_next = 8'(port_a_direction);
				ADDR_PB_DIR: rd_next = 8'(port_b_direction);
				ADDR_PA_OPT: rd_next = 8'(port_a_pin_options);
				ADDR_PB_OPT: rd_next = 8'(port_b_pin_options);
				ADDR_CONV_RES: rd_next = conv_result_in;
				ADDR_CONV_CTL: rd_next = {1'b0, conv_status_in, 6'h00};
				ADDR_TMR_PSC: rd_next = timer_prescaler;
				ADDR_TMR_CNT: rd_next = timer_downcounter;
				ADDR_TMR_STC: rd_next = timer_status_control;
				ADDR_WDG: rd_next = watchdog_counter;
				default: rd_next = RD_UNMAPPED;
			endcase
		end
	end

	// Registered read data
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			data_rdata <= RD_UNMAPPED;
		else if (data_rd)
			data_rdata <= rd_next;
	end

	// Pin drive: direction high drives, option clear with input enables pull-up
	assign port_a_out = port_a_output_latch;
	assign port_b_out = port_b_output_latch;
	assign port_a_oe = port_a_direction;
	assign port_b_oe = port_b_direction;
	assign port_a_pullup = ~port_a_direction & ~port_a_pin_options;
	assign port_b_pullup = ~port_b_direction & ~port_b_pin_options;
	assign conv_control = converter_control;
	assign interrupt_options_q = interrupt_options;
	assign timer_prescaler_q = timer_prescaler;
	assign timer_downcounter_q = timer_downcounter;
	assign timer_status_control_q = timer_status_control;
	assign watchdog_counter_q = watchdog_counter;
endmodule
`default_nettype wire

// ---- bench/core_model.sv ----
// Processor core model issuing data space writes and reads
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input wire logic clk_sys, // Core clock
	output logic [7:0] data_addr, // Data address
	output logic data_wr, // Write strobe
	output logic data_rd, // Read strobe
	output logic [7:0] data_wdata // Write value
);
	// Idle bus at time zero
	initial
	begin
		{data_addr, data_wdata} = '0;
		{data_wr, data_rd} = '0;
	end
	// Whole-byte write, no bit set or clear on ports
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		data_addr <= a;
		data_wdata <= d;
		data_wr <= 1'b1;
		@(posedge clk_sys);
		data_wr <= 1'b0;
		data_wdata <= ~d;
	endtask
	// One-cycle read strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		data_addr <= a;
		data_rd <= 1'b1;
		@(posedge clk_sys);
		data_rd <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- bench/mem_map_decoder_chk.sv ----
// Concurrent checks on the data space decoder ports
`timescale 1ns/1ps
`default_nettype none
module mem_map_decoder_chk
	import mem_map_pkg::*;
#(
	parameter int PORT_W = 8
)
(
	input wire logic clk_sys, // Clock
	input wire logic srst, // Reset
	input wire logic [7:0] data_addr, // Address
	input wire logic data_wr, // Write
	input wire logic data_rd, // Read
	input wire logic [7:0] data_wdata, // Write value
	input wire logic [7:0] data_rdata, // Read value
	input wire logic stack_push, // Push
	input wire logic stack_pop, // Pop
	input wire logic stack_full, // Full
	input wire logic protect_opt, // Protection
	input wire logic ext_rd, // Readout
	input wire logic [7:0] ext_rdata, // Readout data
	input wire logic ext_refused, // Refused
	input wire logic [PORT_W-1:0] port_a_oe, // Drive enables
	input wire logic [PORT_W-1:0] port_a_pullup, // Pull-ups
	input wire logic [PORT_W-1:0] port_a_out, // Port A drive values
	input wire logic [PORT_W-1:0] port_b_out, // Port B drive values
	input wire logic [PORT_W-1:0] port_b_oe, // Port B drive enables
	input wire logic [PORT_W-1:0] port_b_pullup, // Port B pull-ups
	input wire logic [7:0] conv_result_in, // Converter value
	input wire logic [7:0] conv_control, // Converter control
	input wire logic [7:0] interrupt_options_q, // Interrupt options
	input wire logic [7:0] timer_prescaler_q, // Prescaler
	input wire logic [7:0] timer_downcounter_q, // Downcounter
	input wire logic [7:0] timer_status_control_q, // Timer status control
	input wire logic [7:0] watchdog_counter_q // Watchdog
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	// Bus request at one address
	sequence s_wr(logic [7:0] a);
		data_wr && data_addr == a;
	endsequence
	sequence s_rd(logic [7:0] a);
		data_rd && data_addr == a;
	endsequence
	a_reset_timer: assert property ($past(srst) |->
		timer_prescaler_q == 8'h7F && timer_downcounter_q == 8'hFF
		&& watchdog_counter_q == 8'hFE && timer_status_control_q == 8'h00)
		else $error("timer or watchdog reset value wrong");
	a_reset_conv: assert property ($past(srst) |-> conv_control == 8'h40)
		else $error("converter control reset value wrong");
	a_reset_pins: assert property ($past(srst) |-> port_a_oe == '0
		&& port_a_pullup == {PORT_W{1'b1}})
		else $error("pins not input with pull-up after reset");
	a_reset_port_b: assert property ($past(srst) |-> port_b_oe == '0
		&& port_b_pullup == {PORT_W{1'b1}} && port_b_out == '0)
		else $error("port B not input with pull-up after reset");
	a_latch_drive: assert property (s_wr(ADDR_PA_LATCH) |=>
		port_a_out == $past(data_wdata[PORT_W-1:0]))
		else $error("port A latch write not driven");
	a_dir_write: assert property (s_wr(ADDR_PA_DIR) |=>
		port_a_oe == $past(data_wdata[PORT_W-1:0]))
		else $error("direction write not applied");
	a_intopt_write: assert property (s_wr(ADDR_INT_OPT) |=>
		interrupt_options_q == $past(data_wdata))
		else $error("interrupt option write not applied");
	a_conv_read: assert property (s_rd(ADDR_CONV_RES) |=>
		data_rdata == $past(conv_result_in))
		else $error("converter result read wrong");
	a_winsel_read: assert property (s_rd(ADDR_WIN_SEL) |=>
		data_rdata == 8'h00)
		else $error("write-only select read not blanked");
	a_readout_refuse: assert property (ext_rd && protect_opt |=>
		ext_refused && ext_rdata == 8'h00)
		else $error("protected readout not refused");
	a_stack_cap: assert property (stack_full && stack_push && !stack_pop
		|=> stack_full)
		else $error("stack lost full state on extra push");
	a_rdata_hold: assert property (!data_rd |=> $stable(data_rdata))
		else $error("read data changed without read");
endmodule
bind mem_map_decoder mem_map_decoder_chk #(.PORT_W(PORT_W)) chk_i (
	.clk_sys(clk_sys), .srst(srst), .data_addr(data_addr),
	.data_wr(data_wr), .data_rd(data_rd), .data_wdata(data_wdata),
	.data_rdata(data_rdata), .stack_push(stack_push),
	.stack_pop(stack_pop), .stack_full(stack_full),
	.protect_opt(protect_opt), .ext_rd(ext_rd), .ext_rdata(ext_rdata),
	.ext_refused(ext_refused), .port_a_oe(port_a_oe),
	.port_a_pullup(port_a_pullup), .conv_result_in(conv_result_in),
	.port_a_out(port_a_out), .port_b_out(port_b_out),
	.port_b_oe(port_b_oe), .port_b_pullup(port_b_pullup),
	.timer_status_control_q(timer_status_control_q),
	.conv_control(conv_control),
	.interrupt_options_q(interrupt_options_q),
	.timer_prescaler_q(timer_prescaler_q),
	.timer_downcounter_q(timer_downcounter_q),
	.watchdog_counter_q(watchdog_counter_q));
`default_nettype wire

// ---- bench/mcu_memory_space_register_map_bench.sv ----
// Self-checking bench for the data space decoder
`timescale 1ns/1ps
`default_nettype none
module mcu_memory_space_register_map_bench;
	import mem_map_pkg::*;
	logic clk_sys, srst, data_wr, data_rd, stack_push, stack_pop;
	logic protect_opt, full_erase, prog_load_we, ext_rd, conv_status_in;
	logic [7:0] data_addr, data_wdata, data_rdata, prog_rdata, ext_rdata;
	logic [7:0] prog_load_data, conv_result_in, pa_pin, pb_pin, v, p;
	logic [11:0] prog_counter, stack_wdata, stack_top, prog_load_addr;
	logic [11:0] ext_addr, wa;
	logic stack_full, stack_empty, ext_refused, rd_d = 1'b0;
	logic [31:0] seed = 32'h61610624;
	logic [7:0] q[$];
	logic [7:0] ra[15] = '{8'hC0, 8'hC1, 8'hC4, 8'hC5, 8'hCC, 8'hCD, 8'hD2,
		8'hD3, 8'hD4, 8'hD8, 8'hD1, 8'hC8, 8'hC9, 8'hC2, 8'hD0};
	logic [7:0] re[15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h7F,
		8'hFF, 8'h00, 8'hFE, 8'h40, 8'h00, 8'h00, 8'h00, 8'h3C};
	logic [7:0] rw[15] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'hBF, 8'hFF,
		8'hC4, 8'hC5, 8'hCC, 8'hCD, 8'hD2, 8'hD3, 8'hD4, 8'hD8};
	int n_errors = 0, checks_done = 0, cyc = 0;
	core_model core_model_i (.clk_sys(clk_sys), .data_addr(data_addr),
		.data_wr(data_wr), .data_rd(data_rd), .data_wdata(data_wdata));
	mem_map_decoder #(.PORT_W(8)) mem_map_decoder_i (.clk_sys(clk_sys),
		.srst(srst), .data_addr(data_addr), .data_wr(data_wr),
		.data_rd(data_rd), .data_wdata(data_wdata), .data_rdata(data_rdata),
		.prog_counter(prog_counter), .prog_rdata(prog_rdata),
		.stack_push(stack_push), .stack_pop(stack_pop),
		.stack_wdata(stack_wdata), .stack_top(stack_top),
		.stack_full(stack_full), .stack_empty(stack_empty),
		.protect_opt(protect_opt), .full_erase(full_erase),
		.prog_load_we(prog_load_we), .prog_load_addr(prog_load_addr),
		.prog_load_data(prog_load_data), .ext_rd(ext_rd),
		.ext_addr(ext_addr), .ext_rdata(ext_rdata),
		.ext_refused(ext_refused), .port_a_pin(pa_pin), .port_b_pin(pb_pin),
		.port_a_out(), .port_a_oe(), .port_a_pullup(), .port_b_out(),
		.port_b_oe(), .port_b_pullup(), .conv_result_in(conv_result_in),
		.conv_status_in(conv_status_in), .conv_control(),
		.interrupt_options_q(), .timer_prescaler_q(),
		.timer_downcounter_q(), .timer_status_control_q(),
		.watchdog_counter_q());
	// Free-running clock
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Pseudo-random byte from the feedback register
	function automatic logic [7:0] lfsr();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e)
		begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Note the expected byte, then issue the read
	task automatic rdx(input logic [7:0] a, input logic [7:0] e);
		q.push_back(e);
		core_model_i.rd(a);
	endtask
	task automatic ld(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		{prog_load_we, prog_load_addr, prog_load_data} <= {1'b1, a, d};
		@(posedge clk_sys);
		prog_load_we <= 1'b0;
	endtask
	task automatic stk(input logic pu, input logic [11:0] d);
		@(posedge clk_sys);
		{stack_push, stack_pop, stack_wdata} <= {pu, !pu, d};
		@(posedge clk_sys);
		{stack_push, stack_pop} <= 2'b00;
		#1;
	endtask
	task automatic xr(input logic [11:0] a);
		@(posedge clk_sys);
		{ext_rd, ext_addr} <= {1'b1, a};
		@(posedge clk_sys);
		ext_rd <= 1'b0;
		#1;
	endtask
	task wrap_up();
		$display("checks=%0d errors=%0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Read watcher: compare with the oldest note; cycle ceiling
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (rd_d)
			chk(data_rdata, q.pop_front());
		rd_d <= data_rd;
		if (cyc == 20000)
		begin
			n_errors++;
			wrap_up();
		end
	end
	// Main sequence
	initial
	begin
		{srst, stack_push, stack_pop, protect_opt, full_erase} = 5'b10001;
		{prog_load_we, ext_rd, conv_status_in} = 3'b001;
		{prog_counter, stack_wdata, prog_load_addr, ext_addr} = '0;
		{prog_load_data, pa_pin, pb_pin} = '0;
		conv_result_in = 8'h3C;
		repeat (20) @(posedge clk_sys);
		srst <= 1'b0;
		full_erase <= 1'b0;
		for (int i = 0; i < 15; i++)
			rdx(ra[i], re[i]);
		$display("test reset values done");
		for (int i = 0; i < 15; i++)
		begin
			v = lfsr();
			core_model_i.wr(rw[i], v);
			rdx(rw[i], v);
		end
		core_model_i.wr(8'hD0, 8'h55);
		rdx(8'hD0, 8'h3C);
		core_model_i.wr(8'hC2, 8'h55);
		rdx(8'hC2, 8'h00);
		core_model_i.wr(8'hC8, lfsr());
		rdx(8'hC8, 8'h00);
		conv_status_in <= 1'b0;
		core_model_i.wr(8'hD1, 8'hFF);
		rdx(8'hD1, 8'h00);
		$display("test read write access done");
		{pa_pin, pb_pin} <= {lfsr(), lfsr()}; // All eight pins present
		core_model_i.wr(8'hC4, 8'hF0);
		core_model_i.wr(8'hC0, 8'hA5);
		core_model_i.wr(8'hC5, 8'h0F);
		core_model_i.wr(8'hC1, 8'h3C);
		repeat (3) @(posedge clk_sys);
		rdx(8'hC0, 8'hA0 | (pa_pin & 8'h0F));
		rdx(8'hC1, 8'h0C | (pb_pin & 8'hF0));
		$display("test port read-back done");
		p = lfsr();
		for (int i = 0; i < 2; i++)
		begin
			wa = {p[5:0], (i == 0) ? 6'h00 : 6'h3F};
			v = lfsr();
			ld(wa, v);
			core_model_i.wr(8'hC9, {2'b00, p[5:0]}); // Select first
			rdx(8'h40 | {2'b00, wa[5:0]}, v);
			@(posedge clk_sys) prog_counter <= wa;
			repeat (2) @(posedge clk_sys);
			chk(prog_rdata, v);
		end
		$display("test data window done");
		chk(stack_empty, 1'b1);
		for (int i = 0; i < 6; i++)
			stk(1'b1, 12'hA00 + 12'(i));
		chk(stack_full, 1'b1);
		stk(1'b1, 12'hFFF);
		for (int i = 5; i >= 0; i--)
		begin
			chk(stack_top, 12'hA00 + 12'(i));
			stk(1'b0, 12'h000);
		end
		chk(stack_empty, 1'b1);
		$display("test return stack done");
		ld(12'h123, 8'h5A);
		xr(12'h123);
		chk({ext_refused, ext_rdata}, 9'h05A);
		@(posedge clk_sys) protect_opt <= 1'b1;
		xr(12'h123);
		chk({ext_refused, ext_rdata}, 9'h100);
		@(posedge clk_sys) protect_opt <= 1'b0;
		xr(12'h123);
		chk(ext_refused, 1'b1);
		@(posedge clk_sys) full_erase <= 1'b1;
		@(posedge clk_sys) full_erase <= 1'b0;
		xr(12'h123);
		chk({ext_refused, ext_rdata}, {1'b0, ERASED_BYTE});
		$display("test readout protection done");
		repeat (3) @(posedge clk_sys);
		wrap_up();
	end
endmodule
`default_nettype wire
